// ---- core/nhc_fast_rx.sv ----
`timescale 1ns/100ps
// Link-domain shifter for the fast serial selection port
module nhc_fast_rx
  import nhc_pkg::*;
(
  // Link clock and core reset
  input wire logic link_clk,
  input wire logic sys_rst,
  // Serial data pin
  input wire logic data_pin,
  // Word towards core
  nhc_sel_if.tx sel
);
  logic rs1_reg; // Reset crossing, read only by rs2_reg
  logic rs2_reg;
  logic [NHC_SW-1:0] shift_reg;
  logic [3:0] cnt_reg; // Bits taken in current word
  logic last_bit;
  assign last_bit = (cnt_reg == 4'(NHC_SW - 1));
  // ------------------------------------------------------------
  // Reset crossing, needs link edges during reset
  // ------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    rs1_reg <= sys_rst;
    rs2_reg <= rs1_reg;
  end
  // ------------------------------------------------------------
  // Shift MSB first; 16th bit completes the word
  // ------------------------------------------------------------
  always_ff @(posedge link_clk) begin
    if (rs2_reg) begin
      shift_reg <= '0;
      cnt_reg <= '0;
      sel.word <= '0;
      sel.toggle <= 1'b0;
    end else begin
      shift_reg <= {shift_reg[NHC_SW-2:0], data_pin};
      cnt_reg <= cnt_reg + 4'd1;
      if (last_bit) begin
        sel.word <= {shift_reg[NHC_SW-2:0], data_pin};
        sel.toggle <= ~sel.toggle;
      end
    end
  end
  // Word hand-over exactly on the sixteenth bit
  word_toggle_a: assert property (@(posedge link_clk) disable iff (rs2_reg)
    last_bit |=> (sel.toggle != $past(sel.toggle)) && (sel.word[0] == $past(data_pin)))
    else $error("fast word not handed over on sixteenth bit");
  word_cover_c: cover property (@(posedge link_clk) disable iff (rs2_reg) last_bit);
endmodule

// ---- core/nhc_pin_sync.sv ----
`timescale 1ns/100ps
// Three-stage synchroniser, change accepted when stages two and three agree
module nhc_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous inputs and filtered outputs
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_reg; // Read only by s2_reg
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] agree; // Bits whose last two stages match
  assign agree = ~(s2_reg ^ s3_reg);
  // ------------------------------------------------------------
  // Stages and accept
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      dout <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dout <= (agree & s3_reg) | (~agree & dout);
    end
  end
  // Output only moves to an agreed value
  sync_agree_a: assert property (@(posedge clk) disable iff (rst)
    (dout != $past(dout)) |-> (dout == $past(s3_reg)))
    else $error("synchroniser output changed without agreement");
endmodule

// ---- core/nhc_pkg.sv ----
// Operation
// - Four words per band oscillator, two bands
// - Phase continuous or phase coherent mode
// - Continuous mode keeps accumulating without jump
// - Coherent phase aligned to system reference
// - Positive rotation default, negative when configured
// - Word is 48-bit two's complement
// - Six bytes per word, LSB lowest address
// - Page select 0x08, 0x10, 0x18 both
// - Write 0x00 then 0x30 loads words
// - 0x3B selects A/B, 0x41 selects C/D
// - Single band: 3-bit selector, zero bit
// - 0xFF at 0x235 selects register source
// - Masked reference pulse resets phase accumulators
// - 0x03 at 0x234 gives pin selection
// - Mode 3: pins low, serial pins high
// - 0x43 gives fast serial selection port
// - Output settles within filter flush time
// - Fast word 16 bits, channel D top
package nhc_pkg;
  // ------------------------------------------------------------
  // Widths and counts
  // ------------------------------------------------------------
  localparam int NHC_PW = 48; // Frequency word and phase width
  localparam int NHC_AW = 16; // Register address width
  localparam int NHC_DW = 8; // Register data width
  localparam int NHC_NOSC = 8; // Four channels, two bands each
  localparam int NHC_WPP = 16; // Words per oscillator page
  localparam int NHC_SW = 16; // Selection word width
  localparam logic [2:0] NHC_BPW = 3'd6; // Bytes per word
  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam logic [15:0] A_PAGE = 16'h0005;
  localparam logic [15:0] A_BAND = 16'h002c;
  localparam logic [15:0] A_SEL_AB = 16'h003b;
  localparam logic [15:0] A_SEL_CD = 16'h0041;
  localparam logic [15:0] A_PINMODE = 16'h0234;
  localparam logic [15:0] A_SRC = 16'h0235;
  localparam logic [15:0] A_OPT = 16'h0237;
  localparam logic [15:0] A_STAT = 16'h0238;
  localparam logic [15:0] A_MASK0 = 16'h0357;
  localparam logic [15:0] A_MASK1 = 16'h0358;
  localparam logic [15:0] A_FW_LO = 16'h0100;
  localparam logic [15:0] A_FW_HI = 16'h017d;
  localparam logic [15:0] A_LOAD = 16'h0181;
  // ------------------------------------------------------------
  // Register values and fields
  // ------------------------------------------------------------
  localparam logic [7:0] PG_DIG = 8'h02;
  localparam logic [7:0] PG_BOTH = 8'h18;
  localparam int PG_AB_BIT = 3;
  localparam int PG_CD_BIT = 4;
  localparam logic [7:0] LD_ARM_VAL = 8'h00;
  localparam logic [7:0] LD_GO_VAL = 8'h30;
  localparam logic [7:0] SRC_REG_VAL = 8'hff;
  localparam logic [7:0] MASK0_OSC = 8'ha2;
  localparam logic [7:0] MASK1_OSC = 8'h02;
  localparam logic [7:0] SEL_ZERO_MASK = 8'h44;
  localparam logic [15:0] FAST_ZERO_MASK = 16'h4444;
  localparam int SELM_LSB = 5;
  localparam int GPM_LSB = 0;
  localparam logic [1:0] SELM_PIN = 2'h0;
  localparam logic [1:0] SELM_FAST = 2'h2;
  localparam logic [1:0] SELM_MIX = 2'h3;
  localparam logic [1:0] GPM_SEL = 2'h3;
  localparam int BAND_DUAL_BIT = 0;
  localparam int OPT_COH_BIT = 0;
  localparam int OPT_NEG_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAST_BIT = 1;
  localparam int NIB_B1_LSB = 0;
  localparam int NIB_B2_LSB = 2;
  localparam int NIB_BANK = 3;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 8000; // Worst flush, decimation 128
  localparam int SETTLE_CYC = SETTLE_NS / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_REGS = 2'b00,
    SRC_PINS = 2'b01,
    SRC_MIX = 2'b10,
    SRC_FAST = 2'b11
  } nhc_src_e;
  typedef enum logic {
    LD_IDLE = 1'b0,
    LD_ARMED = 1'b1
  } nhc_load_e;
endpackage

// ---- core/nhc_sel_if.sv ----
`timescale 1ns/100ps
// Fast serial word handed from link domain to core domain
interface nhc_sel_if;
  logic [15:0] word; // Stable between toggles
  logic toggle; // Flips once per complete word
  modport tx (output word, output toggle);
  modport rx (input word, input toggle);
endinterface

// ---- core/nhc_top.sv ----
`timescale 1ns/100ps
// Oscillator frequency-hop control for four channels
module nhc_top #(
  parameter int SETTLE_CYCLES = nhc_pkg::SETTLE_CYC
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Fast serial link clock (second general-purpose pin)
  input wire logic link_clk,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [nhc_pkg::NHC_AW-1:0] reg_addr,
  input wire logic [nhc_pkg::NHC_DW-1:0] reg_wdata,
  output logic [nhc_pkg::NHC_DW-1:0] reg_rdata,
  output logic reg_rvalid,
  // Selection and reference pins
  input wire logic select_pin_one,
  input wire logic select_pin_two,
  input wire logic serial_enable_pin,
  input wire logic serial_data_pin,
  input wire logic interface_select_pin,
  input wire logic sysref_pin,
  // Oscillator phases and status
  output logic [nhc_pkg::NHC_NOSC*nhc_pkg::NHC_PW-1:0] phase_o,
  output logic [nhc_pkg::NHC_SW-1:0] sel_word_o,
  output logic hop_busy_o
);
  import nhc_pkg::*;
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] page_reg; // Page select
  logic [7:0] band_reg; // Single or dual band
  logic [7:0] sel_ab_reg; // Channel A/B selectors
  logic [7:0] sel_cd_reg; // Channel C/D selectors
  logic [7:0] pinmode_reg; // Selection and pin mode
  logic [7:0] src_cfg_reg; // Register source override
  logic [7:0] opt_reg; // Phase mode and rotation
  logic [7:0] mask0_reg; // Reference mask, low
  logic [7:0] mask1_reg; // Reference mask, high
  logic [NHC_PW-1:0] fw_store [2][NHC_WPP]; // Written words
  logic [NHC_PW-1:0] fw_act [2][NHC_WPP]; // Loaded words
  nhc_load_e ld_reg [2]; // Load command sequence per page
  nhc_src_e src_reg; // Registered selection source
  logic [NHC_SW-1:0] sel_word_reg; // Applied selection
  logic [NHC_SW-1:0] fast_word_reg; // Last fast serial word
  logic [15:0] settle_cnt_reg; // Flush time remaining
  logic [NHC_PW-1:0] time_reg; // Samples since reference
  logic [2:0] tog_sync_reg; // Toggle crossing stages
  logic tog_seen_reg; // Last accepted toggle
  logic ref_seen_reg; // Reference level last cycle
  // ------------------------------------------------------------
  // Pin synchronisers and fast serial link
  // ------------------------------------------------------------
  logic [5:0] pins_raw;
  logic [5:0] pins_s; // Filtered: ref, ifs, data, en, two, one
  nhc_sel_if sel_link ();
  assign pins_raw = {sysref_pin, interface_select_pin, serial_data_pin,
                     serial_enable_pin, select_pin_two, select_pin_one};
  nhc_pin_sync #(.W(6)) u_pin_sync (
    .clk(core_clk),
    .rst(sys_rst),
    .din(pins_raw),
    .dout(pins_s)
  );
  nhc_fast_rx u_fast_rx (
    .link_clk(link_clk),
    .sys_rst(sys_rst),
    .data_pin(select_pin_one),
    .sel(sel_link.tx)
  );
  wire p_one = pins_s[0];
  wire p_two = pins_s[1];
  wire p_en = pins_s[2];
  wire p_data = pins_s[3];
  wire p_ifs = pins_s[4];
  wire p_ref = pins_s[5];
  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire dig = (page_reg == PG_DIG);
  wire [1:0] pg_hit = {page_reg[PG_CD_BIT], page_reg[PG_AB_BIT]};
  wire wr_dig = reg_wr && dig;
  wire [15:0] fw_off = reg_addr - A_FW_LO;
  wire [3:0] fw_widx = fw_off[6:3];
  wire [2:0] fw_bidx = fw_off[2:0];
  wire fw_hit = (reg_addr >= A_FW_LO) && (reg_addr <= A_FW_HI)
                && (fw_bidx < NHC_BPW);
  wire wr_fw = reg_wr && fw_hit;
  wire wr_load = reg_wr && (reg_addr == A_LOAD);
  wire dual = band_reg[BAND_DUAL_BIT];
  wire coh = opt_reg[OPT_COH_BIT];
  wire neg = opt_reg[OPT_NEG_BIT];
  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      page_reg <= '0;
      band_reg <= '0;
      sel_ab_reg <= '0;
      sel_cd_reg <= '0;
      pinmode_reg <= '0;
      src_cfg_reg <= '0;
      opt_reg <= '0;
      mask0_reg <= '0;
      mask1_reg <= '0;
    end else begin
      if (reg_wr && reg_addr == A_PAGE) page_reg <= reg_wdata;
      if (wr_dig && reg_addr == A_BAND) band_reg <= reg_wdata;
      if (wr_dig && reg_addr == A_SEL_AB) sel_ab_reg <= reg_wdata;
      if (wr_dig && reg_addr == A_SEL_CD) sel_cd_reg <= reg_wdata;
      if (wr_dig && reg_addr == A_PINMODE) pinmode_reg <= reg_wdata;
      if (wr_dig && reg_addr == A_SRC) src_cfg_reg <= reg_wdata;
      if (wr_dig && reg_addr == A_OPT) opt_reg <= reg_wdata;
      if (wr_dig && reg_addr == A_MASK0) mask0_reg <= reg_wdata;
      if (wr_dig && reg_addr == A_MASK1) mask1_reg <= reg_wdata;
    end
  end
  // ------------------------------------------------------------
  // Word storage and load command, per page
  // ------------------------------------------------------------
  logic [1:0] load_go; // Second half of load command seen
  for (genvar p = 0; p < 2; p++) begin : page_g
    wire wr_here = pg_hit[p];
    assign load_go[p] = wr_load && wr_here && (ld_reg[p] == LD_ARMED)
                        && (reg_wdata == LD_GO_VAL);
    // Byte write, least significant byte at lowest address
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        // Cleared words keep every phase free of unknowns before programming
        fw_store[p] <= '{default: '0};
      end else if (wr_fw && wr_here) begin
        fw_store[p][fw_widx][{fw_bidx, 3'b000} +: 8] <= reg_wdata;
      end
    end
    // Loaded copy changes as a whole, never byte by byte
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        fw_act[p] <= '{default: '0};
      end else if (load_go[p]) begin
        fw_act[p] <= fw_store[p];
      end
    end
    // Arm on 0x00, load on following 0x30
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        ld_reg[p] <= LD_IDLE;
      end else if (wr_load && wr_here) begin
        ld_reg[p] <= (reg_wdata == LD_ARM_VAL) ? LD_ARMED : LD_IDLE;
      end
    end
  end
  // ------------------------------------------------------------
  // Fast serial word crossing by toggle
  // ------------------------------------------------------------
  wire tog_agree = (tog_sync_reg[1] == tog_sync_reg[2]);
  wire fast_new = tog_agree && (tog_sync_reg[2] != tog_seen_reg);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tog_sync_reg <= '0;
      tog_seen_reg <= 1'b0;
      fast_word_reg <= '0;
    end else begin
      tog_sync_reg <= {tog_sync_reg[1:0], sel_link.toggle};
      if (tog_agree) tog_seen_reg <= tog_sync_reg[2];
      // Word has been stable since the toggle left the link domain
      if (fast_new) fast_word_reg <= sel_link.word;
    end
  end
  // ------------------------------------------------------------
  // Selection source and word
  // ------------------------------------------------------------
  wire [1:0] selm = pinmode_reg[SELM_LSB +: 2];
  wire [1:0] gpm = pinmode_reg[GPM_LSB +: 2];
  wire src_force = (src_cfg_reg == SRC_REG_VAL);
  wire src_pins = (selm == SELM_PIN) && (gpm == GPM_SEL);
  wire src_mix = p_ifs && (selm == SELM_MIX);
  wire src_fast = p_ifs && (selm == SELM_FAST) && (gpm == GPM_SEL);
  nhc_src_e src_next;
  assign src_next = src_force ? SRC_REGS :
                    src_pins ? SRC_PINS :
                    src_mix ? SRC_MIX :
                    src_fast ? SRC_FAST : SRC_REGS;
  // Pins drive the two-bit selectors of every channel alike
  wire [3:0] pin_nib = dual ? {p_two, p_one, p_two, p_one}
                            : {2'b00, p_two, p_one};
  wire [3:0] mix_nib = dual ? {p_data, p_en, p_two, p_one}
                            : {p_data, 1'b0, p_two, p_one};
  wire [15:0] single_keep = dual ? 16'hffff : ~FAST_ZERO_MASK;
  wire [15:0] reg_word = {sel_cd_reg, sel_ab_reg} & single_keep;
  wire [15:0] sel_word_next =
    (src_reg == SRC_PINS) ? {4{pin_nib}} :
    (src_reg == SRC_MIX) ? {4{mix_nib}} :
    (src_reg == SRC_FAST) ? (fast_word_reg & single_keep) :
    reg_word;
  wire sel_chg = (sel_word_next != sel_word_reg) || (|load_go);
  // ------------------------------------------------------------
  // Selection applied whole, once per sample clock
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      src_reg <= SRC_REGS;
      sel_word_reg <= '0;
    end else begin
      src_reg <= src_next;
      sel_word_reg <= sel_word_next;
    end
  end
  assign sel_word_o = sel_word_reg;
  // ------------------------------------------------------------
  // Settle timer: worst-case filter flush after a hop
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      settle_cnt_reg <= '0;
      hop_busy_o <= 1'b0;
    end else if (sel_chg) begin
      settle_cnt_reg <= 16'(SETTLE_CYCLES);
      hop_busy_o <= 1'b1;
    end else begin
      if (settle_cnt_reg != '0) settle_cnt_reg <= settle_cnt_reg - 16'd1;
      hop_busy_o <= (settle_cnt_reg > 16'd1);
    end
  end
  // ------------------------------------------------------------
  // Reference pulse to oscillators through the mask
  // ------------------------------------------------------------
  wire ref_route = (mask0_reg == MASK0_OSC) && (mask1_reg == MASK1_OSC);
  wire ref_hit = ref_route && p_ref && !ref_seen_reg;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ref_seen_reg <= 1'b0;
      time_reg <= '0;
    end else begin
      ref_seen_reg <= p_ref;
      // Common time base makes every word's phase a pure function of it
      time_reg <= ref_hit ? '0 : time_reg + 48'd1;
    end
  end
  // ------------------------------------------------------------
  // Oscillator phase per channel and band
  // ------------------------------------------------------------
  for (genvar o = 0; o < NHC_NOSC; o++) begin : osc_g
    localparam int C = o / 2;
    localparam int B = o % 2;
    localparam logic PG = 1'(C / 2);
    wire [3:0] nib = sel_word_reg[C*4 +: 4];
    wire [2:0] idx = (B == 0) ? {~dual & nib[NIB_BANK], nib[NIB_B1_LSB +: 2]}
                              : {1'b1, nib[NIB_B2_LSB +: 2]};
    wire used = (B == 0) || dual;
    wire [NHC_PW-1:0] fw = fw_act[PG][{1'(C % 2), idx}];
    wire [NHC_PW-1:0] coh_ph = NHC_PW'(time_reg * fw);
    logic [NHC_PW-1:0] acc_reg;
    logic [NHC_PW-1:0] ph_reg;
    wire [NHC_PW-1:0] ph = coh ? coh_ph : acc_reg;
    // Accumulator continues from present phase at the new rate
    always_ff @(posedge core_clk) begin
      if (sys_rst || ref_hit) begin
        acc_reg <= '0;
      end else begin
        acc_reg <= acc_reg + fw;
      end
    end
    // Negative rotation is the conjugate, i.e. negated phase
    always_ff @(posedge core_clk) begin
      if (sys_rst || !used) begin
        ph_reg <= '0;
      end else begin
        ph_reg <= neg ? -ph : ph;
      end
    end
    assign phase_o[o*NHC_PW +: NHC_PW] = ph_reg;
  end
  // ------------------------------------------------------------
  // Read-back
  // ------------------------------------------------------------
  wire [7:0] sel_rd_mask = dual ? 8'hff : ~SEL_ZERO_MASK;
  wire [7:0] stat = 8'({src_reg == SRC_FAST, hop_busy_o})
                    << STAT_BUSY_BIT;
  wire rp = !pg_hit[0];
  wire [NHC_PW-1:0] fw_rd = fw_store[rp][fw_widx];
  wire [7:0] rd_next =
    (reg_addr == A_PAGE) ? page_reg :
    (dig && reg_addr == A_BAND) ? band_reg :
    (dig && reg_addr == A_SEL_AB) ? (sel_ab_reg & sel_rd_mask) :
    (dig && reg_addr == A_SEL_CD) ? (sel_cd_reg & sel_rd_mask) :
    (dig && reg_addr == A_PINMODE) ? pinmode_reg :
    (dig && reg_addr == A_SRC) ? src_cfg_reg :
    (dig && reg_addr == A_OPT) ? opt_reg :
    (dig && reg_addr == A_STAT) ? stat :
    (dig && reg_addr == A_MASK0) ? mask0_reg :
    (dig && reg_addr == A_MASK1) ? mask1_reg :
    (fw_hit && |pg_hit) ? fw_rd[{fw_bidx, 3'b000} +: 8] : 8'h00;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) reg_rdata <= rd_next;
    end
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  load_copy_a: assert property (load_go[0] |=>
    fw_act[0][0] == $past(fw_store[0][0]))
    else $error("load command did not copy stored word");
  src_force_a: assert property ((wr_dig && reg_addr == A_SRC
    && reg_wdata == SRC_REG_VAL) |=> ##1 src_reg == SRC_REGS)
    else $error("register source not taken after override");
  both_pages_a: assert property ((page_reg == PG_BOTH) |->
    pg_hit == 2'b11)
    else $error("both-page select does not hit both pages");
  ref_clear_a: assert property (ref_hit |=>
    osc_g[0].acc_reg == '0 && time_reg == '0)
    else $error("reference pulse did not clear phase");
  phase_cont_a: assert property (!ref_hit |=>
    osc_g[0].acc_reg == $past(osc_g[0].acc_reg) + $past(osc_g[0].fw))
    else $error("phase accumulator jumped");
  coh_time_a: assert property ((!ref_hit && !$past(ref_hit) && !$past(sys_rst)) |->
    time_reg == $past(time_reg) + 48'd1)
    else $error("coherent time base skipped");
  single_zero_a: assert property ((reg_rd && !dual && dig
    && reg_addr == A_SEL_AB) |=> (reg_rdata & SEL_ZERO_MASK) == '0)
    else $error("single-band zero bit read as one");
  settle_start_a: assert property (sel_chg |=>
    settle_cnt_reg == 16'(SETTLE_CYCLES) && hop_busy_o)
    else $error("settle timer not started on hop");
  neg_rot_a: assert property ((neg && !ref_hit && $stable(neg)) |=>
    osc_g[0].ph_reg == -$past(osc_g[0].ph))
    else $error("negative rotation not applied");
  apply_whole_a: assert property ($changed(sel_word_reg) |->
    sel_word_reg == $past(sel_word_next))
    else $error("selection applied partially");
  load_cover_c: cover property (load_go[0] ##1 sel_chg);
  fast_cover_c: cover property (src_reg == SRC_FAST && fast_new);
  ref_cover_c: cover property (ref_hit && coh);
endmodule

// ---- tb/nhc_host_model.sv ----
`timescale 1ns/100ps
// Host driving the fast selection port
module nhc_host_model (
  // Link pins
  output logic link_clk,
  output logic link_data
);
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
  end
  // MSB first, clock stands low between words
  task automatic shift(input logic [15:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      link_data = w[i];
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
    end
    // Released line shows the inverse, not a stale bit
    link_data = ~w[0];
    // Idle half period, so the next frame never reassigns data in this step
    #62.5;
  endtask
endmodule

// ---- tb/nhc_top_tb.sv ----
`timescale 1ns/100ps
module nhc_top_tb;
  import nhc_pkg::*;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
  logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, hop_busy_o;
  logic [15:0] reg_addr = '0, sel_word_o;
  logic [7:0] reg_wdata = '0, reg_rdata;
  logic p1 = 1'b0, p2 = 1'b0, en = 1'b0, sd = 1'b0, ifs = 1'b0, sref = 1'b0, fast_on = 1'b0;
  logic link_clk, link_data;
  logic [NHC_NOSC*NHC_PW-1:0] phase_o;
  logic [47:0] p0;
  int error_cnt = 0, tests_run = 0;
  // Address, data, applied selection word
  logic [39:0] rows [4] = '{{A_SEL_AB, 8'he4, 16'h00e4}, {A_SEL_CD, 8'h27, 16'h27e4},
    {A_SEL_AB, 8'h00, 16'h2700}, {A_SEL_CD, 8'hff, 16'hff00}};
  always #5 core_clk = ~core_clk;
  nhc_host_model u_nhc_host_model (.link_clk(link_clk), .link_data(link_data));
  nhc_top #(.SETTLE_CYCLES(20)) u_nhc_top (.core_clk(core_clk), .sys_rst(sys_rst),
    .link_clk(link_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .select_pin_one(fast_on ? link_data : p1), .select_pin_two(fast_on ? link_clk : p2),
    .serial_enable_pin(en), .serial_data_pin(sd), .interface_select_pin(ifs),
    .sysref_pin(sref), .phase_o(phase_o), .sel_word_o(sel_word_o), .hop_busy_o(hop_busy_o));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    `CHK(reg_rvalid, 1'b1)
    `CHK(reg_rdata, e)
    tick(1);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    #300us;
    error_cnt++;
    wrap_up();
  end
  initial begin
    // Link side reset needs link edges too
    u_nhc_host_model.shift(16'h0000, 3);
    tick(3);
    sys_rst = 1'b0;
    `CHK(sel_word_o, 16'h0000)
    // Two link edges let the link side leave reset before any frame
    u_nhc_host_model.shift(16'h0000, 2);
    tick(1);
    wr(A_PAGE, PG_DIG);
    wr(A_BAND, 8'h01);
    foreach (rows[i]) begin
      wr(rows[i][39:24], rows[i][23:16]);
      `CHK(sel_word_o, rows[i][15:0])
      `CHK(hop_busy_o, 1'b1)
      rd(rows[i][39:24], rows[i][23:16]);
    end
    tick(25);
    `CHK(hop_busy_o, 1'b0)
    // Wrong page hides digital registers
    wr(A_PAGE, PG_BOTH);
    rd(A_SEL_AB, 8'h00);
    // Words 0 and 1 of both pages hold 3 and 1
    for (int b = 0; b < 6; b++) begin
      wr(16'(A_FW_LO + b), b == 0 ? 8'h03 : 8'h00);
      wr(16'(A_FW_LO + 8 + b), b == 0 ? 8'h01 : 8'h00);
    end
    wr(A_LOAD, LD_ARM_VAL);
    wr(A_LOAD, LD_GO_VAL);
    wr(A_PAGE, 8'h10);
    rd(16'(A_FW_LO + 8), 8'h01);
    wr(A_PAGE, PG_DIG);
    wr(A_SEL_AB, 8'h00);
    tick(300);
    p0 = phase_o[47:0];
    tick(1);
    `CHK(phase_o[47:0] - p0, 48'd3)
    wr(A_MASK0, MASK0_OSC);
    wr(A_MASK1, MASK1_OSC);
    sref = 1'b1;
    tick(10);
    `CHK(phase_o[47:0] < 48'd60, 1'b1)
    wr(A_MASK0, 8'h00);
    wr(A_MASK1, 8'h00);
    // Coherent: a two-cycle hop to word 1 and back leaves phase on 3 * time
    wr(A_OPT, 8'h01);
    wr(A_SEL_AB, 8'h01);
    wr(A_SEL_AB, 8'h00);
    tick(2);
    `CHK(phase_o[47:0] % 48'd3, 48'd0)
    wr(A_OPT, 8'h03);
    p0 = phase_o[47:0];
    tick(1);
    `CHK(p0 - phase_o[47:0], 48'd3)
    // Single band: zero bits read back clear
    wr(A_BAND, 8'h00);
    wr(A_SEL_AB, 8'hff);
    rd(A_SEL_AB, 8'hbb);
    wr(A_BAND, 8'h01);
    p1 = 1'b1;
    wr(A_PINMODE, 8'h03);
    tick(8);
    `CHK(sel_word_o, 16'h5555)
    ifs = 1'b1;
    sd = 1'b1;
    wr(A_PINMODE, 8'h60);
    tick(8);
    `CHK(sel_word_o, 16'h9999)
    wr(A_PINMODE, 8'h43);
    fast_on = 1'b1;
    u_nhc_host_model.shift(16'h1e2d, 16);
    u_nhc_host_model.shift(16'hc3a5, 16);
    tick(12);
    `CHK(sel_word_o, 16'hc3a5)
    wr(A_SRC, SRC_REG_VAL);
    tick(2);
    `CHK(sel_word_o, 16'hffff)
    wrap_up();
  end
endmodule
